// file: bsre_core.sv
// Execution unit for bit, stack, return and rotate instructions
// ============================================================
`timescale 1ns/100ps
`default_nettype none

module bsre_core
   import bsre_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic irq_ack,
   output logic in_service_flag,
   output logic [15:0] instr_pointer
);

   // ==========================================================
   // Helpers
   function automatic logic [15:0] fit(input logic [15:0] v,
                                       input logic w16);
      fit = w16 ? v : {8'h00, v[7:0]};
   endfunction : fit

   function automatic logic top_bit(input logic [15:0] v,
                                    input logic w16);
      top_bit = w16 ? v[15] : v[7];
   endfunction : top_bit

   // ==========================================================
   // State
   bsre_bus_phase_type phase_reg;
   logic phase_valid_reg;
   logic [15:0] acc_reg, acc_next;
   bsre_flags_type flags_reg, flags_next;
   logic ins_reg, ins_next;
   logic bad_reg, bad_next;
   logic [15:0] sp_reg, sp_next;
   logic [15:0] ip_reg, ip_next;
   logic [15:0] src_reg, src_next;
   logic [7:0] prefix_reg, prefix_next;
   logic w16_reg, w16_next;
   logic [15:0] last_op_reg, last_op_next;
   logic [6:0] modaddr_reg, modaddr_next;
   logic [3:0] stkaddr_reg, stkaddr_next;
   logic [31:0] hrdata_reg;
   logic [15:0] stack_mem [STK_DEPTH];
   logic [15:0] mod_mem [MOD_SLOTS];

   // ==========================================================
   // Bus decode
   wire addr_phase = hsel & hready & htrans[1];
   wire bus_wr = phase_valid_reg & phase_reg.wr;
   wire [7:0] wa = phase_reg.addr;
   wire [15:0] wd = hwdata[15:0];
   // Writing the instruction register executes it at the edge ending its data phase,
   // so a read right behind it samples in that same edge and still sees the old value.
   wire exec = bus_wr & (wa == OFS_INSTR);
   wire [15:0] op = wd;

   // ==========================================================
   // Module register slots (modules 0..5 and system module 8)
   wire [3:0] dst_mod = op[11:8];
   wire [2:0] dst_idx = op[14:12];
   wire dst_supported = (dst_mod <= MOD_LAST_PERIPH) |
                        (dst_mod == MOD_SYS);
   wire [2:0] dst_slot_hi = (dst_mod == MOD_SYS) ? MOD_SYS_SLOT
                                                 : dst_mod[2:0];
   wire [5:0] dst_slot = {dst_slot_hi, dst_idx};
   wire dst_is_psf = (op[14:8] == DST_PSF);
   wire dst_is_acc = (op[14:8] == DST_ACC);

   wire [3:0] src_mod = op[3:0];
   wire src_supported = (src_mod <= MOD_LAST_PERIPH) | (src_mod == MOD_SYS);
   wire [2:0] src_slot_hi = (src_mod == MOD_SYS) ? MOD_SYS_SLOT
                                                 : src_mod[2:0];
   wire [5:0] src_slot = {src_slot_hi, op[6:4]};
   wire src_is_psf = (op[6:0] == DST_PSF);
   wire [15:0] src_reg_val = src_is_psf ? {12'h000, flags_reg} :
                             src_supported ? mod_mem[src_slot] : src_reg;
   // Immediate form: high byte from prefix only in the 16-bit variant
   wire [15:0] src_imm = {w16_reg ? prefix_reg : 8'h00, op[7:0]};
   wire [15:0] src_val = op[15] ? src_reg_val : src_imm;

   wire [5:0] mod_win_slot = {(modaddr_reg[3:0] == MOD_SYS) ?
                              MOD_SYS_SLOT : modaddr_reg[2:0],
                              modaddr_reg[6:4]};

   // ==========================================================
   // Opcode classes
   wire is_clr_c = (op == OP_CLR_C);
   wire is_set_c = (op == OP_SET_C);
   wire is_neg = (op == OP_NEG);
   wire is_rl = (op == OP_ROT_L);
   wire is_rlc = (op == OP_ROT_LC);
   wire is_rr = (op == OP_ROT_R);
   wire is_rrc = (op == OP_ROT_RC);
   wire is_orbit = (op[15:8] == OP_ORBIT_HI) & (op[3:0] == NIB_A);
   // Accumulator as OR source is reused by the OR-carry-with-bit form
   wire is_or = (op[14:8] == OP_OR_SEL) & ~is_orbit;
   wire is_btc = (op[11:8] == NIB_7);
   wire is_bitwr = op[15] & (op[3:0] == NIB_7) & ~is_btc;
   wire is_push = (op[14:8] == STK_CODE);
   wire is_stk_lo = op[15] & (op[6:0] == STK_CODE) & ~is_push;
   wire is_ret = is_stk_lo & (op[11:8] == NIB_C);
   wire is_pop = is_stk_lo & ~is_ret;
   wire unmask = op[7];

   // ==========================================================
   // Datapath terms
   wire [15:0] acc_f = fit(acc_reg, w16_reg);
   wire acc_msb = top_bit(acc_f, w16_reg);
   wire [3:0] bit_ix = op[7:4];
   wire bit_ix_ok = w16_reg | ~bit_ix[3];
   wire [15:0] res_neg = fit(~acc_f + 16'h0001, w16_reg);
   wire [15:0] res_or = fit(acc_f | src_val, w16_reg);
   wire [15:0] acc_shl = {acc_f[14:0], 1'b0};
   wire [15:0] res_rl = fit(acc_shl | {15'h0000, acc_msb}, w16_reg);
   wire [15:0] res_rlc = fit(acc_shl | {15'h0000, flags_reg.c}, w16_reg);
   wire [15:0] acc_shr = {1'b0, acc_f[15:1]};
   wire [15:0] msb_mask = w16_reg ? 16'h8000 : 16'h0080;
   // Feed into the msb for the active width
   wire [15:0] res_rr = acc_shr | (acc_f[0] ? msb_mask : 16'h0000);
   wire [15:0] res_rrc = acc_shr | (flags_reg.c ? msb_mask : 16'h0000);

   wire [15:0] stk_top = stack_mem[sp_reg[3:0]];
   wire [15:0] sp_inc = sp_reg + 16'h0001;
   wire [15:0] sp_dec = sp_reg - 16'h0001;
   wire [15:0] ip_inc = ip_reg + 16'h0001;

   logic cond_ok;
   logic cond_bad;
   always_comb begin
      cond_ok = 1'b0;
      cond_bad = 1'b0;
      case (op[14:12])
         CND_ALWAYS: cond_ok = 1'b1;
         CND_C: cond_ok = flags_reg.c;
         CND_NC: cond_ok = ~flags_reg.c;
         CND_Z: cond_ok = flags_reg.z;
         CND_NZ: cond_ok = ~flags_reg.z;
         CND_S: cond_ok = flags_reg.s;
         default: cond_bad = 1'b1;
      endcase
   end

   wire [15:0] bit_mask = 16'h0001 << op[6:4];
   wire [15:0] bw_old = dst_is_psf ? {12'h000, flags_reg}
                                   : mod_mem[dst_slot];
   wire [15:0] bw_new = op[7] ? (bw_old | bit_mask)
                              : (bw_old & ~bit_mask);
   wire bw_ok = dst_is_psf | dst_supported;

   // ==========================================================
   // Memory write enables
   logic stk_we;
   logic [3:0] stk_wa;
   logic [15:0] stk_wd;
   logic mod_we;
   logic [5:0] mod_wa;
   logic [15:0] mod_wd;

   // ==========================================================
   // Next state
   always_comb begin
      acc_next = acc_reg;
      flags_next = flags_reg;
      ins_next = ins_reg;
      bad_next = bad_reg;
      sp_next = sp_reg;
      ip_next = ip_reg;
      src_next = src_reg;
      prefix_next = prefix_reg;
      w16_next = w16_reg;
      last_op_next = last_op_reg;
      modaddr_next = modaddr_reg;
      stkaddr_next = stkaddr_reg;
      stk_we = 1'b0;
      stk_wa = stkaddr_reg;
      stk_wd = wd;
      mod_we = 1'b0;
      mod_wa = mod_win_slot;
      mod_wd = wd;
      if (bus_wr) begin
         case (wa)
            OFS_ACC: acc_next = fit(wd, w16_reg);
            OFS_STATUS: begin
               flags_next = wd[3:0];
               ins_next = wd[STAT_INS_BIT];
               if (wd[STAT_BAD_BIT]) begin
                  bad_next = 1'b0;
               end
            end
            OFS_SP: sp_next = wd;
            OFS_IP: ip_next = wd;
            OFS_SRC: src_next = wd;
            OFS_PREFIX: prefix_next = wd[7:0];
            OFS_CONFIG: w16_next = wd[CFG_W16_BIT];
            OFS_MODADDR: modaddr_next = wd[6:0];
            OFS_STKADDR: stkaddr_next = wd[3:0];
            OFS_MODDATA: mod_we = 1'b1;
            OFS_STKDATA: stk_we = 1'b1;
            default: ;
         endcase
      end
      if (exec) begin
         last_op_next = op;
         ip_next = ip_inc;
         if (is_clr_c) begin
            flags_next.c = 1'b0;
         end else if (is_set_c) begin
            flags_next.c = 1'b1;
         end else if (is_neg | is_or | is_rl | is_rlc | is_rr | is_rrc) begin
            acc_next = is_neg ? res_neg : is_or ? res_or :
                       is_rl ? res_rl : is_rlc ? res_rlc :
                       is_rr ? res_rr : res_rrc;
            flags_next.s = top_bit(acc_next, w16_reg);
            // Plain rotates leave zero alone
            if (~is_rl & ~is_rr) begin
               flags_next.z = (acc_next == 16'h0000);
            end
            if (is_rlc) begin
               flags_next.c = acc_msb;
            end
            if (is_rrc) begin
               flags_next.c = acc_f[0];
            end
         end else if (is_orbit) begin
            if (bit_ix_ok) begin
               flags_next.c = flags_reg.c | acc_f[bit_ix];
            end else begin
               bad_next = 1'b1;
            end
         end else if (is_btc) begin
            flags_next.c = src_val[op[14:12]];
         end else if (is_bitwr) begin
            if (~bw_ok) begin
               bad_next = 1'b1;
            end else if (dst_is_psf) begin
               flags_next = bw_new[3:0];
            end else begin
               mod_we = 1'b1;
               mod_wa = dst_slot;
               mod_wd = bw_new;
            end
         end else if (is_push) begin
            sp_next = sp_inc;
            stk_we = 1'b1;
            stk_wa = sp_inc[3:0];
            stk_wd = src_val;
         end else if (is_ret) begin
            if (cond_bad) begin
               bad_next = 1'b1;
            end else if (cond_ok) begin
               ip_next = stk_top;
               sp_next = sp_dec;
               if (unmask) begin
                  ins_next = 1'b0;
               end
            end
         end else if (is_pop) begin
            sp_next = sp_dec;
            if (unmask) begin
               ins_next = 1'b0;
            end
            if (dst_is_acc) begin
               acc_next = fit(stk_top, w16_reg);
               flags_next.s = top_bit(acc_next, w16_reg);
               flags_next.z = (acc_next == 16'h0000);
            end else if (dst_is_psf) begin
               flags_next = stk_top[3:0];
            end else if (dst_supported) begin
               mod_we = 1'b1;
               mod_wa = dst_slot;
               mod_wd = stk_top;
            end
         end else begin
            bad_next = 1'b1;
         end
      end
      // Interrupt acknowledge wins over a clear in the same cycle
      if (irq_ack) begin
         ins_next = 1'b1;
      end
   end

   // ==========================================================
   // Read mux, sampled in the address phase
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      case (haddr[7:0])
         OFS_INSTR: rd_val = {16'h0000, last_op_reg};
         OFS_ACC: rd_val = {16'h0000, acc_reg};
         OFS_STATUS: rd_val = {26'h000_0000, bad_reg, ins_reg, flags_reg};
         OFS_SP: rd_val = {16'h0000, sp_reg};
         OFS_IP: rd_val = {16'h0000, ip_reg};
         OFS_SRC: rd_val = {16'h0000, src_reg};
         OFS_PREFIX: rd_val = {24'h00_0000, prefix_reg};
         OFS_CONFIG: rd_val = {31'h0000_0000, w16_reg};
         OFS_MODADDR: rd_val = {25'h000_0000, modaddr_reg};
         OFS_MODDATA: rd_val = {16'h0000, mod_mem[mod_win_slot]};
         OFS_STKADDR: rd_val = {28'h000_0000, stkaddr_reg};
         OFS_STKDATA: rd_val = {16'h0000, stack_mem[stkaddr_reg]};
         default: rd_val = 32'h0000_0000;
      endcase
      if (haddr[31:8] != 24'h00_0000) begin
         rd_val = 32'h0000_0000;
      end
   end

   wire addr_mapped = (haddr[31:8] == 24'h00_0000);

   // ==========================================================
   // Registers
   always_ff @(posedge clk) begin
      if (srst) begin
         phase_valid_reg <= 1'b0;
         phase_reg <= '0;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         phase_valid_reg <= addr_phase & addr_mapped;
         phase_reg <= '{wr: hwrite, addr: haddr[7:0]};
         if (addr_phase & ~hwrite) begin
            hrdata_reg <= rd_val;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         acc_reg <= 16'h0000;
         flags_reg <= '0;
         ins_reg <= 1'b0;
         bad_reg <= 1'b0;
         sp_reg <= SP_RESET;
         ip_reg <= IP_RESET;
         src_reg <= 16'h0000;
         prefix_reg <= 8'h00;
         w16_reg <= 1'b1;
         last_op_reg <= 16'h0000;
         modaddr_reg <= 7'h00;
         stkaddr_reg <= 4'h0;
      end else begin
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         ins_reg <= ins_next;
         bad_reg <= bad_next;
         sp_reg <= sp_next;
         ip_reg <= ip_next;
         src_reg <= src_next;
         prefix_reg <= prefix_next;
         w16_reg <= w16_next;
         last_op_reg <= last_op_next;
         modaddr_reg <= modaddr_next;
         stkaddr_reg <= stkaddr_next;
      end
   end

   // Memories carry no reset; software must set what it reads back
   always_ff @(posedge clk) begin
      if (stk_we) begin
         stack_mem[stk_wa] <= stk_wd;
      end
      if (mod_we) begin
         mod_mem[mod_wa] <= mod_wd;
      end
   end

   // ==========================================================
   // Outputs
   // Ready and response are flops held at constant levels
   logic hready_one_reg;
   logic hresp_reg;
   always_ff @(posedge clk) begin
      hready_one_reg <= 1'b1;
      hresp_reg <= 1'b0;
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hready_one_reg;
   assign hresp = hresp_reg;
   assign in_service_flag = ins_reg;
   assign instr_pointer = ip_reg;

endmodule : bsre_core

`default_nettype wire

// file: bsre_pkg.sv
// Package for the bit, stack, return and rotate execution block
package bsre_pkg;

   // ==========================================================
   // Register map (byte offsets on the AHB-Lite bus)
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_ACC = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_SP = 8'h0C;
   localparam logic [7:0] OFS_IP = 8'h10;
   localparam logic [7:0] OFS_SRC = 8'h14;
   localparam logic [7:0] OFS_PREFIX = 8'h18;
   localparam logic [7:0] OFS_CONFIG = 8'h1C;
   localparam logic [7:0] OFS_MODADDR = 8'h20;
   localparam logic [7:0] OFS_MODDATA = 8'h24;
   localparam logic [7:0] OFS_STKADDR = 8'h28;
   localparam logic [7:0] OFS_STKDATA = 8'h2C;

   // ==========================================================
   // Field positions and reset values
   localparam int STAT_INS_BIT = 4;
   localparam int STAT_BAD_BIT = 5;
   localparam int CFG_W16_BIT = 0;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [15:0] IP_RESET = 16'h0000;
   localparam int STK_DEPTH = 16;
   localparam int MOD_SLOTS = 64;

   // ==========================================================
   // Opcodes and opcode fields
   localparam logic [15:0] OP_CLR_C = 16'hDA0A;
   localparam logic [15:0] OP_SET_C = 16'hDA1A;
   localparam logic [15:0] OP_NEG = 16'h8A9A;
   localparam logic [15:0] OP_ROT_L = 16'h8A4A;
   localparam logic [15:0] OP_ROT_LC = 16'h8A5A;
   localparam logic [15:0] OP_ROT_R = 16'h8ACA;
   localparam logic [15:0] OP_ROT_RC = 16'h8ADA;
   localparam logic [7:0] OP_ORBIT_HI = 8'hAA;
   localparam logic [3:0] NIB_A = 4'hA;
   localparam logic [3:0] NIB_7 = 4'h7;
   localparam logic [3:0] NIB_C = 4'hC;
   localparam logic [6:0] OP_OR_SEL = 7'h2A;
   localparam logic [6:0] STK_CODE = 7'h0D;
   localparam logic [6:0] DST_ACC = 7'h0A;
   localparam logic [6:0] DST_PSF = 7'h48;
   localparam logic [3:0] MOD_SYS = 4'h8;
   localparam logic [3:0] MOD_LAST_PERIPH = 4'h5;
   localparam logic [2:0] MOD_SYS_SLOT = 3'h7;

   // Return conditions in opcode bits 14:12
   localparam logic [2:0] CND_ALWAYS = 3'h0;
   localparam logic [2:0] CND_C = 3'h2;
   localparam logic [2:0] CND_NC = 3'h6;
   localparam logic [2:0] CND_Z = 3'h1;
   localparam logic [2:0] CND_NZ = 3'h5;
   localparam logic [2:0] CND_S = 3'h4;

   // ==========================================================
   // Types
   typedef struct packed {
      logic e;
      logic z;
      logic s;
      logic c;
   } bsre_flags_type;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
   } bsre_bus_phase_type;

endpackage : bsre_pkg

// file: bsre_core_checker.sv
// Port checker for the bit, stack, return and rotate block
`timescale 1ns/100ps
`default_nettype none

module bsre_core_checker
   import bsre_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic irq_ack,
   input wire logic in_service_flag,
   input wire logic [15:0] instr_pointer
);
   // ==========================================================
   // Data phase tracking
   logic wr_next;
   logic wr_reg;
   logic exe_next;
   logic exe_reg;
   logic [15:0] op_word;
   assign wr_next = hsel && hready && htrans[1] && hwrite;
   assign exe_next = wr_next && haddr == {24'h000000, OFS_INSTR};
   assign op_word = hwdata[15:0];
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_reg <= 1'h0;
         exe_reg <= 1'h0;
      end else begin
         wr_reg <= wr_next;
         exe_reg <= exe_next;
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   ready_always_a: assert property (hreadyout)
      else $error("hreadyout low");
   resp_okay_a: assert property (!hresp)
      else $error("hresp not OKAY");
   reset_vals_a: assert property ($fell(srst) |->
      instr_pointer == 16'h0000 && !in_service_flag && hrdata == 32'h0)
      else $error("state not cleared by reset");
   ack_sets_a: assert property (irq_ack |=> in_service_flag)
      else $error("in-service flag not set by ack");
   interrupt_return_clears_a: assert property (
      exe_reg && op_word == 16'h8C8D && !irq_ack |=> !in_service_flag)
      else $error("interrupt return left in-service set");
   pop_and_unmask_clears_a: assert property (
      exe_reg && op_word == 16'h8A8D && !irq_ack |=> !in_service_flag)
      else $error("pop-and-unmask left in-service set");
   ip_step_a: assert property (exe_reg && op_word[15:8] == 8'h8A
      && op_word[3:0] == 4'hA |=>
      instr_pointer == $past(instr_pointer) + 16'h0001)
      else $error("pointer did not advance by one");
   ins_hold_a: assert property (!wr_reg && !irq_ack |=>
      $stable(in_service_flag))
      else $error("in-service flag moved without cause");
   ip_hold_a: assert property (!wr_reg |=> $stable(instr_pointer))
      else $error("pointer moved without a write");

endmodule : bsre_core_checker

// Hooked on the core so no bench wiring is needed
bind bsre_core bsre_core_checker bsre_core_checker_i (
   .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .irq_ack(irq_ack), .in_service_flag(in_service_flag),
   .instr_pointer(instr_pointer)
);
`default_nettype wire

// file: bit_stack_return_rotate_exec_bench.sv
// Self-checking bench for the bit, stack, return and rotate block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) \
   begin \
      num_checks++; \
      if ((gt) !== (ex)) begin \
         n_mismatch++; \
         $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
      end \
   end

module bit_stack_return_rotate_exec_bench
   import bsre_pkg::*;
();
   // ==========================================================
   // Signals and design
   logic clk, srst, hsel, hwrite, irq_ack, hresp, hreadyout, hready;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic in_service_flag;
   logic [15:0] instr_pointer;
   int n_mismatch, num_checks;
   logic [15:0] ret_op [6] = '{16'h8C0D, 16'hAC0D, 16'hEC0D, 16'h9C0D,
      16'hDC0D, 16'hCC0D};
   logic [7:0] st_yes [6] = '{8'h00, 8'h01, 8'h00, 8'h04, 8'h00, 8'h02};
   logic [7:0] st_no [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h04, 8'h00};
   assign hready = hreadyout;

   bsre_core bsre_core_i (.clk(clk), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq_ack(irq_ack),
      .in_service_flag(in_service_flag), .instr_pointer(instr_pointer));

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   // ==========================================================
   // Bus tasks
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // Bounded so a stuck slave ends the run instead of hanging it
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'h1 && n < 20);
      if (hready !== 1'h1) begin
         n_mismatch++;
         print_verdict();
      end
   endtask : wait_ready

   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'h1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'h1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string nm);
      logic [31:0] q;
      xfer(1'h0, a, 32'h0, q);
      `CHK(nm, e, q)
   endtask : rd

   task automatic exec(input logic [15:0] op);
      wr(OFS_INSTR, {16'h0000, op});
   endtask : exec

   // ==========================================================
   // Scenario tasks
   // Status write of bit5 clears the sticky bad flag before each case
   task automatic acc_op(input logic w16, input logic [15:0] op,
      input logic [15:0] ai, input logic [7:0] si, input logic [15:0] ao,
      input logic [7:0] so);
      wr(OFS_CONFIG, {31'h0, w16});
      wr(OFS_ACC, {16'h0000, ai});
      wr(OFS_STATUS, {26'h0, 1'h1, si[4:0]});
      exec(op);
      rd(OFS_ACC, {16'h0000, ao}, "acc");
      rd(OFS_STATUS, {24'h0, so}, "status");
   endtask : acc_op

   task automatic mod_bit(input logic [6:0] code, input logic [15:0] op,
      input logic [15:0] di, input logic [15:0] dout);
      wr(OFS_MODADDR, {25'h0, code});
      wr(OFS_MODDATA, {16'h0000, di});
      exec(op);
      rd(OFS_MODDATA, {16'h0000, dout}, "module");
   endtask : mod_bit

   task automatic ret_case(input logic [15:0] op, input logic [7:0] st,
      input logic taken);
      wr(OFS_SP, 32'h1);
      wr(OFS_STKADDR, 32'h1);
      wr(OFS_STKDATA, 32'h0060);
      wr(OFS_IP, 32'h0010);
      wr(OFS_STATUS, {26'h0, 2'h3, st[3:0]});
      exec(op);
      rd(OFS_IP, taken ? 32'h60 : 32'h11, "ip");
      rd(OFS_SP, taken ? 32'h0 : 32'h1, "sp");
      `CHK("ins", !(taken && op[7]), in_service_flag)
      `CHK("ip port", taken ? 16'h0060 : 16'h0011, instr_pointer)
   endtask : ret_case

   // ==========================================================
   // Main sequence
   initial begin
      srst = 1'h1;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      irq_ack = 1'h0;
      n_mismatch = 0;
      num_checks = 0;
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      `CHK("ip port", 16'h0000, instr_pointer)
      `CHK("ins port", 1'h0, in_service_flag)
      rd(OFS_CONFIG, 32'h1, "config");
      rd(8'h30, 32'h0, "unmapped");
      `CHK("hresp", 1'h0, hresp)
      acc_op(1'h1, OP_NEG, 16'hFEED, 8'h01, 16'h0113, 8'h01);
      acc_op(1'h1, OP_NEG, 16'h0000, 8'h02, 16'h0000, 8'h04);
      acc_op(1'h0, OP_NEG, 16'h00FE, 8'h03, 16'h0002, 8'h01);
      acc_op(1'h1, OP_ROT_L, 16'hA345, 8'h04, 16'h468B, 8'h04);
      acc_op(1'h1, OP_ROT_L, 16'h468B, 8'h00, 16'h8D16, 8'h02);
      acc_op(1'h1, OP_ROT_LC, 16'h468B, 8'h01, 16'h8D17, 8'h02);
      acc_op(1'h1, OP_ROT_LC, 16'h8000, 8'h00, 16'h0000, 8'h05);
      acc_op(1'h0, OP_ROT_L, 16'h00A3, 8'h02, 16'h0047, 8'h00);
      acc_op(1'h0, OP_ROT_LC, 16'h00A3, 8'h03, 16'h0047, 8'h01);
      acc_op(1'h1, OP_ROT_R, 16'hA345, 8'h04, 16'hD1A2, 8'h06);
      acc_op(1'h1, OP_ROT_RC, 16'hD1A2, 8'h01, 16'hE8D1, 8'h02);
      acc_op(1'h0, OP_ROT_R, 16'h0045, 8'h00, 16'h00A2, 8'h02);
      // OR sources are a module register, the flags, the source register or an immediate, never the accumulator itself
      wr(OFS_SRC, 32'h0F0F);
      wr(OFS_PREFIX, 32'h11);
      acc_op(1'h1, 16'hAA19, 16'h2345, 8'h00, 16'h2F4F, 8'h00);
      acc_op(1'h1, 16'h2A33, 16'h2345, 8'h00, 16'h3377, 8'h00);
      acc_op(1'h0, 16'h2A00, 16'h0000, 8'h02, 16'h0000, 8'h04);
      acc_op(1'h1, 16'hAA1A, 16'h2345, 8'h00, 16'h2345, 8'h00);
      acc_op(1'h1, 16'hAADA, 16'h2345, 8'h06, 16'h2345, 8'h07);
      acc_op(1'h0, 16'hAADA, 16'h0045, 8'h00, 16'h0045, 8'h20);
      wr(OFS_SRC, 32'h0004);
      acc_op(1'h1, 16'hA719, 16'h1234, 8'h06, 16'h1234, 8'h07);
      acc_op(1'h1, 16'h8719, 16'h1234, 8'h07, 16'h1234, 8'h06);
      acc_op(1'h1, OP_SET_C, 16'h1234, 8'h06, 16'h1234, 8'h07);
      acc_op(1'h1, OP_CLR_C, 16'h1234, 8'h0F, 16'h1234, 8'h0E);
      acc_op(1'h1, 16'h8687, 16'h1234, 8'h00, 16'h1234, 8'h20);
      acc_op(1'h1, 16'hC8A7, 16'h1234, 8'h01, 16'h1234, 8'h05);
      acc_op(1'h1, 16'hC807, 16'h1234, 8'h05, 16'h1234, 8'h04);
      mod_bit(7'h00, 16'h8017, 16'h00FE, 16'h00FC);
      mod_bit(7'h00, 16'h8077, 16'h00FC, 16'h007C);
      mod_bit(7'h25, 16'hA587, 16'h0000, 16'h0001);
      mod_bit(7'h08, 16'h88F7, 16'h0000, 16'h0080);
      wr(OFS_SP, 32'h0);
      wr(OFS_PREFIX, 32'h0);
      wr(OFS_SRC, 32'h0F3F);
      wr(OFS_STATUS, 32'h27);
      exec(16'h0D40);
      exec(16'h8D19);
      rd(OFS_SP, 32'h2, "sp");
      rd(OFS_STATUS, 32'h7, "status");
      wr(OFS_STKADDR, 32'h1);
      rd(OFS_STKDATA, 32'h0040, "stack");
      wr(OFS_STKADDR, 32'h2);
      rd(OFS_STKDATA, 32'h0F3F, "stack");
      exec(16'h8A0D);
      rd(OFS_ACC, 32'h0F3F, "acc");
      rd(OFS_SP, 32'h1, "sp");
      rd(OFS_STATUS, 32'h1, "status");
      irq_ack <= 1'h1;
      @(posedge clk);
      irq_ack <= 1'h0;
      @(posedge clk);
      `CHK("ins port", 1'h1, in_service_flag)
      exec(16'h8A8D);
      rd(OFS_ACC, 32'h0040, "acc");
      rd(OFS_SP, 32'h0, "sp");
      `CHK("ins port", 1'h0, in_service_flag)
      for (int i = 0; i < 6; i++) begin
         for (int j = 0; j < 4; j++) begin
            ret_case(ret_op[i] | {8'h00, j[0], 7'h00},
               j[1] ? st_yes[i] : st_no[i], j[1] || i == 0);
         end
      end
      print_verdict();
   end

endmodule : bit_stack_return_rotate_exec_bench
`default_nettype wire
